// ---- logic/cpal_autoreset.sv ----
`timescale 1ns/10ps
// Auto-reset alarm: counts events in an hour window opened by the first event, latches at limit.
module cpal_autoreset
	import cpal_pkg::*;
#(
	parameter int CNT_W = 8,
	parameter int SEC_W = 12
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             sec_tick,
	input  wire logic             cond,
	input  wire logic             count_en,
	input  wire logic [CNT_W-1:0] limit,
	input  wire logic             manual_reset,
	output logic                  alarm,
	output logic                  latched
);

	cpal_state_t      state_ff, nxt_state;
	logic [CNT_W-1:0] count_ff, nxt_count;
	logic [SEC_W-1:0] age_ff,   nxt_age;
	logic             rise;

	assign rise = cond && state_ff == CPAL_IDLE;

	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		nxt_age   = age_ff;
		// Window restarts at the first event; simpler than per-event stamps
		if (sec_tick && count_ff != '0) begin
			if (age_ff == SEC_W'(CPAL_HOUR_S - 1)) begin
				nxt_age   = '0;
				nxt_count = '0;
			end else begin
				nxt_age = age_ff + 1'b1;
			end
		end
		case (state_ff)
			CPAL_IDLE: begin
				if (rise) begin
					nxt_state = CPAL_ACTIVE;
					if (count_en) begin
						nxt_count = count_ff + 1'b1;
						if (count_ff == '0)
							nxt_age = '0;
					end
				end
			end
			CPAL_ACTIVE: begin
				if (count_ff >= limit && limit != '0)
					nxt_state = CPAL_LATCHED;
				else if (!cond)
					nxt_state = CPAL_IDLE;
			end
			CPAL_LATCHED: begin
				if (manual_reset && !cond) begin
					nxt_state = CPAL_IDLE;
					nxt_count = '0;
				end
			end
			default: nxt_state = CPAL_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_ff <= CPAL_IDLE;
			count_ff <= '0;
			age_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			age_ff   <= nxt_age;
		end
	end

	assign alarm   = state_ff != CPAL_IDLE;
	assign latched = state_ff == CPAL_LATCHED;

	latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		latched && !manual_reset |=> latched)
		else $error("latched alarm cleared without manual reset");

endmodule : cpal_autoreset

// ---- logic/cpal_pkg.sv ----
package cpal_pkg;

	// ------------------------------------------------------------
	// Alarm codes (letter prefix E plus two-digit number)
	// ------------------------------------------------------------
	localparam logic [7:0] CPAL_CODE_PREFIX = 8'h45;
	localparam logic [7:0] CPAL_CODE_NONE   = 8'h00;
	localparam logic [7:0] CPAL_CODE_CTH    = 8'h03;
	localparam logic [7:0] CPAL_CODE_FTH    = 8'h04;
	localparam logic [7:0] CPAL_CODE_AFZ    = 8'h05;
	localparam logic [7:0] CPAL_CODE_PR2    = 8'h06;
	localparam logic [7:0] CPAL_CODE_PR3    = 8'h07;
	localparam logic [7:0] CPAL_CODE_HPD    = 8'h09;
	localparam logic [7:0] CPAL_CODE_HPA    = 8'h11;

	// ------------------------------------------------------------
	// Load mask bit positions
	// ------------------------------------------------------------
	localparam int CPAL_LOAD_W  = 9;
	localparam int CPAL_LD_C1   = 0;
	localparam int CPAL_LD_C2   = 1;
	localparam int CPAL_LD_C3   = 2;
	localparam int CPAL_LD_C4   = 3;
	localparam int CPAL_LD_FAN1 = 4;
	localparam int CPAL_LD_FAN2 = 5;
	localparam logic [8:0] CPAL_LOADS_ALL  = 9'h1FF;
	localparam logic [8:0] CPAL_LOADS_NONE = 9'h000;
	localparam logic [8:0] CPAL_CIRC1_COMP = 9'h003;
	localparam logic [8:0] CPAL_CIRC2_COMP = 9'h00C;
	localparam logic [8:0] CPAL_CIRC1_FANC = 9'h013;

	// ------------------------------------------------------------
	// Probe range in tenths of a degree, probe function selects
	// ------------------------------------------------------------
	localparam logic signed [15:0] CPAL_PROBE_MIN = -16'sd500;
	localparam logic signed [15:0] CPAL_PROBE_MAX = 16'sd1000;
	localparam logic [1:0] CPAL_FUNC_ANTIFREEZE = 2'h1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CPAL_CLK_HZ   = 50000000;
	localparam int CPAL_TICK_MS  = 1;
	localparam int CPAL_TICK_CYC = CPAL_CLK_HZ / 1000 * CPAL_TICK_MS;
	localparam int CPAL_HOUR_S   = 3600;
	localparam int CPAL_TICKS_PER_S = 1000 / CPAL_TICK_MS;

	typedef enum logic [1:0] {
		CPAL_IDLE    = 2'b00,
		CPAL_ACTIVE  = 2'b01,
		CPAL_LATCHED = 2'b11
	} cpal_state_t;

endpackage : cpal_pkg

// ---- logic/cpal_top.sv ----
`timescale 1ns/10ps
//
// Behaviour
// - Alarm cuts its loads, shows E-code
// - Compressor one thermal input trips compressor one
// - Thermal alarm auto-resets until hourly limit
// - Thermal alarm ignored during start blanking
// - Fan thermal cuts circuit one, combined adds two
// - Fan thermal auto-resets until own limit
// - Antifreeze on probe two below setpoint
// - Antifreeze ends above setpoint plus hysteresis
// - Antifreeze counts after switch-on or heating
// - Antifreeze cuts circuit one compressors, fans
// - Probe two fault cuts all loads
// - Probe three fault cuts all loads
// - High-pressure switch: compressor one, manual only
// - Analogue high pressure over setpoint
// - Pressure alarm clears below setpoint minus hysteresis
//
module cpal_top
	import cpal_pkg::*;
#(
	parameter int CNT_W       = 8,
	parameter int BLANK_W     = 8,
	parameter int TICK_CYC    = CPAL_TICK_CYC,
	parameter int TICKS_PER_S = CPAL_TICKS_PER_S
) (
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic                comp_one_thermal,
	input  wire logic                fan_one_thermal,
	input  wire logic                comp_one_high_pressure,
	input  wire logic                probe_two_short,
	input  wire logic                probe_two_open,
	input  wire logic                probe_three_short,
	input  wire logic                probe_three_open,
	input  wire logic signed [15:0]  probe_two,
	input  wire logic signed [15:0]  probe_three,
	input  wire logic signed [15:0]  probe_four,
	input  wire logic                comp_one_running,
	input  wire logic                unit_switched_on,
	input  wire logic                heating_started,
	input  wire logic                manual_reset,
	input  wire logic [1:0]          probe_two_function_select,
	input  wire logic                probe_two_analogue,
	input  wire logic                probe_three_analogue,
	input  wire logic                probe_three_pressure,
	input  wire logic                probe_four_pressure,
	input  wire logic                combined_condensation,
	input  wire logic [CNT_W-1:0]    comp_thermal_event_limit,
	input  wire logic [BLANK_W-1:0]  comp_thermal_blank_time,
	input  wire logic [CNT_W-1:0]    fan_thermal_event_limit,
	input  wire logic [CNT_W-1:0]    antifreeze_event_limit,
	input  wire logic signed [15:0]  antifreeze_setpoint,
	input  wire logic signed [15:0]  antifreeze_hysteresis,
	input  wire logic signed [15:0]  high_pressure_setpoint,
	input  wire logic signed [15:0]  high_pressure_hysteresis,
	output logic [CPAL_LOAD_W-1:0]   load_off_ff,
	output logic [7:0]               code_prefix_ff,
	output logic [7:0]               code_number_ff,
	output logic [6:0]               alarm_active_ff,
	output logic                     any_latched_ff
);

	// ------------------------------------------------------------
	// Input synchronisers for pins
	// ------------------------------------------------------------
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] pin_raw, sync1_ff, sync2_ff;
	assign pin_raw = {comp_one_thermal, fan_one_thermal, comp_one_high_pressure,
	                  probe_two_short, probe_two_open, probe_three_short,
	                  probe_three_open, unit_switched_on, manual_reset};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= pin_raw;
			sync2_ff <= sync1_ff;
		end
	end

	logic s_cth, s_fth, s_hpd, s_p2s, s_p2o, s_p3s, s_p3o, s_on, s_mrst;
	assign {s_cth, s_fth, s_hpd, s_p2s, s_p2o, s_p3s, s_p3o, s_on, s_mrst} = sync2_ff;

	// ------------------------------------------------------------
	// Millisecond and second ticks
	// ------------------------------------------------------------
	logic [25:0] tick_cnt_ff, nxt_tick_cnt;
	logic [15:0] ms_cnt_ff, nxt_ms_cnt;
	logic        sec_tick_ff, nxt_sec_tick;

	always_comb begin
		nxt_tick_cnt = tick_cnt_ff + 1'b1;
		nxt_ms_cnt   = ms_cnt_ff;
		nxt_sec_tick = 1'b0;
		if (tick_cnt_ff == 26'(TICK_CYC - 1)) begin
			nxt_tick_cnt = '0;
			nxt_ms_cnt   = ms_cnt_ff + 1'b1;
			if (ms_cnt_ff == 16'(TICKS_PER_S - 1)) begin
				nxt_ms_cnt   = '0;
				nxt_sec_tick = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tick_cnt_ff <= '0;
			ms_cnt_ff   <= '0;
			sec_tick_ff <= 1'b0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
			ms_cnt_ff   <= nxt_ms_cnt;
			sec_tick_ff <= nxt_sec_tick;
		end
	end

	// ------------------------------------------------------------
	// Compressor start blanking timer, in seconds
	// ------------------------------------------------------------
	logic [BLANK_W-1:0] blank_ff, nxt_blank;
	logic               run_d_ff;

	always_comb begin
		nxt_blank = blank_ff;
		if (comp_one_running && !run_d_ff)
			nxt_blank = comp_thermal_blank_time;
		else if (sec_tick_ff && blank_ff != '0)
			nxt_blank = blank_ff - 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			blank_ff <= '0;
			run_d_ff <= 1'b0;
		end else begin
			blank_ff <= nxt_blank;
			run_d_ff <= comp_one_running;
		end
	end

	// ------------------------------------------------------------
	// Analogue conditions with hysteresis
	// ------------------------------------------------------------
	logic        afz_ff, nxt_afz;
	logic        hpa_ff, nxt_hpa;
	logic        count_arm_ff, nxt_count_arm;
	logic        on_d_ff;
	logic signed [16:0] afz_off_lvl, hpa_off_lvl, hp_val;
	logic        afz_en, hpa_en;

	function automatic logic probe_bad(input logic sh, input logic op,
	                                   input logic signed [15:0] v);
		probe_bad = sh || op || v < CPAL_PROBE_MIN || v > CPAL_PROBE_MAX;
	endfunction : probe_bad

	assign afz_en      = probe_two_function_select == CPAL_FUNC_ANTIFREEZE;
	assign hpa_en      = probe_three_pressure || probe_four_pressure;
	assign afz_off_lvl = 17'(antifreeze_setpoint) + 17'(antifreeze_hysteresis);
	assign hpa_off_lvl = 17'(high_pressure_setpoint) - 17'(high_pressure_hysteresis);
	assign hp_val      = probe_three_pressure ? 17'(probe_three) : 17'(probe_four);

	always_comb begin
		nxt_afz = afz_ff;
		if (!afz_en)
			nxt_afz = 1'b0;
		else if (probe_two < antifreeze_setpoint)
			nxt_afz = 1'b1;
		else if (17'(probe_two) > afz_off_lvl)
			nxt_afz = 1'b0;
		nxt_hpa = hpa_ff;
		if (!hpa_en)
			nxt_hpa = 1'b0;
		else if (hp_val > 17'(high_pressure_setpoint))
			nxt_hpa = 1'b1;
		else if (hp_val < hpa_off_lvl)
			nxt_hpa = 1'b0;
		// Counting armed from switch-on or heating start
		nxt_count_arm = count_arm_ff || (s_on && !on_d_ff) || heating_started;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			afz_ff       <= 1'b0;
			hpa_ff       <= 1'b0;
			count_arm_ff <= 1'b0;
			on_d_ff      <= 1'b0;
		end else begin
			afz_ff       <= nxt_afz;
			hpa_ff       <= nxt_hpa;
			count_arm_ff <= nxt_count_arm;
			on_d_ff      <= s_on;
		end
	end

	// ------------------------------------------------------------
	// Auto-reset alarm channels
	// ------------------------------------------------------------
	logic cth_cond, cth_al, fth_al, afz_al, cth_lt, fth_lt, afz_lt;
	assign cth_cond = s_cth && blank_ff == '0;

	cpal_autoreset #(.CNT_W(CNT_W)) u_cth (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.sec_tick    (sec_tick_ff),
		.cond        (cth_cond),
		.count_en    (1'b1),
		.limit       (comp_thermal_event_limit),
		.manual_reset(s_mrst),
		.alarm       (cth_al),
		.latched     (cth_lt)
	);

	cpal_autoreset #(.CNT_W(CNT_W)) u_fth (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.sec_tick    (sec_tick_ff),
		.cond        (s_fth),
		.count_en    (1'b1),
		.limit       (fan_thermal_event_limit),
		.manual_reset(s_mrst),
		.alarm       (fth_al),
		.latched     (fth_lt)
	);

	cpal_autoreset #(.CNT_W(CNT_W)) u_afz (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.sec_tick    (sec_tick_ff),
		.cond        (afz_ff),
		.count_en    (count_arm_ff),
		.limit       (antifreeze_event_limit),
		.manual_reset(s_mrst),
		.alarm       (afz_al),
		.latched     (afz_lt)
	);

	// ------------------------------------------------------------
	// Manual-only high-pressure latch and probe faults
	// ------------------------------------------------------------
	logic hpd_ff, nxt_hpd, p2f, p3f;
	always_comb begin
		nxt_hpd = hpd_ff;
		if (s_hpd)
			nxt_hpd = 1'b1;
		else if (s_mrst)
			nxt_hpd = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			hpd_ff <= 1'b0;
		else
			hpd_ff <= nxt_hpd;
	end

	assign p2f = probe_two_analogue && probe_bad(s_p2s, s_p2o, probe_two);
	assign p3f = probe_three_analogue && probe_bad(s_p3s, s_p3o, probe_three);

	// ------------------------------------------------------------
	// Load shutdown and code display; lowest code shown first
	// ------------------------------------------------------------
	logic [CPAL_LOAD_W-1:0] nxt_load_off;
	logic [7:0]             nxt_code;
	logic [6:0]             act;
	assign act = {hpa_ff, hpd_ff, p3f, p2f, afz_al, fth_al, cth_al};

	always_comb begin
		nxt_load_off = CPAL_LOADS_NONE;
		if (cth_al)
			nxt_load_off[CPAL_LD_C1] = 1'b1;
		if (fth_al)
			nxt_load_off = nxt_load_off | CPAL_CIRC1_FANC
			             | (combined_condensation ? CPAL_CIRC2_COMP : CPAL_LOADS_NONE);
		if (afz_al)
			nxt_load_off = nxt_load_off | CPAL_CIRC1_FANC;
		if (hpd_ff)
			nxt_load_off[CPAL_LD_C1] = 1'b1;
		if (hpa_ff)
			nxt_load_off = nxt_load_off | CPAL_CIRC1_COMP;
		if (p2f || p3f)
			nxt_load_off = CPAL_LOADS_ALL;
		nxt_code = CPAL_CODE_NONE;
		if (hpa_ff)      nxt_code = CPAL_CODE_HPA;
		if (hpd_ff)      nxt_code = CPAL_CODE_HPD;
		if (p3f)         nxt_code = CPAL_CODE_PR3;
		if (p2f)         nxt_code = CPAL_CODE_PR2;
		if (afz_al)      nxt_code = CPAL_CODE_AFZ;
		if (fth_al)      nxt_code = CPAL_CODE_FTH;
		if (cth_al)      nxt_code = CPAL_CODE_CTH;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			load_off_ff     <= CPAL_LOADS_NONE;
			code_prefix_ff  <= CPAL_CODE_NONE;
			code_number_ff  <= CPAL_CODE_NONE;
			alarm_active_ff <= '0;
			any_latched_ff  <= 1'b0;
		end else begin
			load_off_ff     <= nxt_load_off;
			code_prefix_ff  <= (nxt_code == CPAL_CODE_NONE) ? CPAL_CODE_NONE : CPAL_CODE_PREFIX;
			code_number_ff  <= nxt_code;
			alarm_active_ff <= act;
			any_latched_ff  <= cth_lt || fth_lt || afz_lt || hpd_ff;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence cth_seen;
		cth_al;
	endsequence

	comp_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cth_seen |=> load_off_ff[CPAL_LD_C1])
		else $error("compressor one not off on thermal alarm");

	blank_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		blank_ff != '0 && !cth_al |=> !cth_al)
		else $error("thermal alarm raised during blanking");

	fan_cut_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fth_al && combined_condensation |=> load_off_ff[CPAL_LD_C3] && load_off_ff[CPAL_LD_FAN1])
		else $error("fan alarm loads wrong");

	afz_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		afz_en && afz_ff && 17'(probe_two) <= afz_off_lvl |=> afz_ff)
		else $error("antifreeze ended inside hysteresis");

	afz_cut_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		afz_al |=> load_off_ff[CPAL_LD_FAN1] && load_off_ff[CPAL_LD_C2])
		else $error("antifreeze loads not off");

	probe_all_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		p2f || p3f |=> load_off_ff == CPAL_LOADS_ALL)
		else $error("probe fault did not cut all loads");

	hp_manual_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		hpd_ff && !s_mrst |=> hpd_ff)
		else $error("high pressure cleared without reset");

	hpa_hyst_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		hpa_en && hpa_ff && hp_val >= hpa_off_lvl |=> hpa_ff)
		else $error("pressure alarm ended inside hysteresis");

endmodule : cpal_top

// ---- sim/cpal_plant_model.sv ----
`timescale 1ns/10ps
module cpal_plant_model
	import cpal_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       comp_demand,
	input  wire logic [8:0] relay_off,
	output logic            comp_run_ff
);
	// ------------------------------------------------------------
	// Compressor one contactor
	// ------------------------------------------------------------
	// Pulls in one cycle late and drops one cycle after it is forced off,
	// so every restart after a trip gives the block a fresh start edge
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			comp_run_ff <= 1'b0;
		end else begin
			comp_run_ff <= comp_demand & ~relay_off[CPAL_LD_C1];
		end
	end
endmodule : cpal_plant_model

// ---- sim/cpal_top_tb_top.sv ----
`timescale 1ns/10ps
module cpal_top_tb_top
	import cpal_pkg::*;
;
	typedef struct packed {
		logic [11:0]        sw;
		logic signed [15:0] p2;
		logic signed [15:0] p3;
		logic signed [15:0] p4;
		logic [8:0]         ld;
		logic [7:0]         num;
		logic [6:0]         act;
	} cpal_row_t;

	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic sys_clk, rst_n = 1'b0, cth = 1'b0, fth = 1'b0, hpd = 1'b0;
	logic p2s = 1'b0, p2o = 1'b0, p3s = 1'b0, p3o = 1'b0, p2a = 1'b0, p3a = 1'b0;
	logic p3p = 1'b0, p4p = 1'b0, comb = 1'b0, dem = 1'b0, uon = 1'b0, heat = 1'b0;
	logic mrst = 1'b0, run;
	logic [1:0] fsel = 2'h0;
	logic signed [15:0] p2 = 16'sd200, p3 = 16'sd0, p4 = 16'sd0;
	logic [7:0] cth_lim = 8'h02, fth_lim = 8'h00, afz_lim = 8'h00, blank = 8'h00;
	logic signed [15:0] af_set = 16'sd50, af_hys = 16'sd30;
	logic signed [15:0] hp_set = 16'sd200, hp_hys = 16'sd50;
	logic [8:0] load_off_ff;
	logic [7:0] code_prefix_ff, code_number_ff;
	logic [6:0] alarm_active_ff;
	logic       any_latched_ff;
	int err_total = 0;
	int n_checks = 0;

	// sw: 11 antifreeze probe, 10 combined, 9 p4 press, 8 p3 press, 7 p3 ana,
	// 6 p2 ana, 5 p3 open, 4 p3 short, 3 p2 open, 2 p2 short, 1 fan, 0 comp
	cpal_row_t rows [0:16] = '{
		'{12'h000, 16'sd200, 16'sd0, 16'sd0, 9'h000, 8'h00, 7'h00},
		'{12'h800, 16'sd50, 16'sd0, 16'sd0, 9'h000, 8'h00, 7'h00},
		'{12'h000, 16'sd40, 16'sd0, 16'sd0, 9'h000, 8'h00, 7'h00},
		'{12'h001, 16'sd200, 16'sd0, 16'sd0, 9'h001, 8'h03, 7'h01},
		'{12'h002, 16'sd200, 16'sd0, 16'sd0, 9'h013, 8'h04, 7'h02},
		'{12'h402, 16'sd200, 16'sd0, 16'sd0, 9'h01F, 8'h04, 7'h02},
		'{12'h800, 16'sd40, 16'sd0, 16'sd0, 9'h013, 8'h05, 7'h04},
		'{12'h044, 16'sd200, 16'sd0, 16'sd0, 9'h1FF, 8'h06, 7'h08},
		'{12'h048, 16'sd200, 16'sd0, 16'sd0, 9'h1FF, 8'h06, 7'h08},
		'{12'h040, 16'sd1100, 16'sd0, 16'sd0, 9'h1FF, 8'h06, 7'h08},
		'{12'h040, 16'sd1000, 16'sd0, 16'sd0, 9'h000, 8'h00, 7'h00},
		'{12'h090, 16'sd200, 16'sd0, 16'sd0, 9'h1FF, 8'h07, 7'h10},
		'{12'h0A0, 16'sd200, 16'sd0, 16'sd0, 9'h1FF, 8'h07, 7'h10},
		'{12'h080, 16'sd200, -16'sd600, 16'sd0, 9'h1FF, 8'h07, 7'h10},
		'{12'h100, 16'sd200, 16'sd250, 16'sd0, 9'h003, 8'h11, 7'h40},
		'{12'h200, 16'sd200, 16'sd0, 16'sd250, 9'h003, 8'h11, 7'h40},
		'{12'h003, 16'sd200, 16'sd0, 16'sd0, 9'h013, 8'h03, 7'h03}
	};

	// Second shortened to four cycles so an hour window fits the run
	cpal_top #(.TICK_CYC(2), .TICKS_PER_S(2)) i_cpal_top (
		.sys_clk(sys_clk), .rst_n(rst_n),
		.comp_one_thermal(cth), .fan_one_thermal(fth),
		.comp_one_high_pressure(hpd),
		.probe_two_short(p2s), .probe_two_open(p2o),
		.probe_three_short(p3s), .probe_three_open(p3o),
		.probe_two(p2), .probe_three(p3), .probe_four(p4),
		.comp_one_running(run), .unit_switched_on(uon),
		.heating_started(heat), .manual_reset(mrst),
		.probe_two_function_select(fsel), .probe_two_analogue(p2a),
		.probe_three_analogue(p3a), .probe_three_pressure(p3p),
		.probe_four_pressure(p4p), .combined_condensation(comb),
		.comp_thermal_event_limit(cth_lim), .comp_thermal_blank_time(blank),
		.fan_thermal_event_limit(fth_lim), .antifreeze_event_limit(afz_lim),
		.antifreeze_setpoint(af_set), .antifreeze_hysteresis(af_hys),
		.high_pressure_setpoint(hp_set), .high_pressure_hysteresis(hp_hys),
		.load_off_ff(load_off_ff), .code_prefix_ff(code_prefix_ff),
		.code_number_ff(code_number_ff), .alarm_active_ff(alarm_active_ff),
		.any_latched_ff(any_latched_ff)
	);

	cpal_plant_model i_cpal_plant_model (
		.sys_clk(sys_clk), .rst_n(rst_n), .comp_demand(dem),
		.relay_off(load_off_ff), .comp_run_ff(run)
	);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : wait_cyc

	task automatic miss(input string what);
		err_total++;
		$display("mismatch %0t %s", $time, what);
	endtask : miss

	task automatic chk_ld(input logic [8:0] exp);
		n_checks++;
		if (load_off_ff !== exp) miss($sformatf("loads %h exp %h", load_off_ff, exp));
	endtask : chk_ld

	task automatic chk_code(input logic [7:0] num);
		logic [7:0] pre;
		pre = (num == 8'h00) ? CPAL_CODE_NONE : CPAL_CODE_PREFIX;
		n_checks++;
		if (code_prefix_ff !== pre || code_number_ff !== num) begin
			miss($sformatf("code %h%h exp %h%h", code_prefix_ff, code_number_ff, pre, num));
		end
	endtask : chk_code

	task automatic chk_act(input logic [6:0] exp);
		n_checks++;
		if (alarm_active_ff !== exp) miss($sformatf("alarms %h exp %h", alarm_active_ff, exp));
	endtask : chk_act

	task automatic chk_latch(input logic exp);
		n_checks++;
		if (any_latched_ff !== exp) miss("latched flag");
	endtask : chk_latch

	// Bounded wait for an alarm pattern; running out ends the run
	task automatic settle(input logic [6:0] exp);
		wait_cyc(8);
		for (int k = 0; k < 40 && alarm_active_ff !== exp; k++) wait_cyc(1);
		if (alarm_active_ff !== exp) begin
			miss("timeout waiting for alarms");
			tally_and_finish();
		end
	endtask : settle

	task automatic drive(input logic [11:0] sw, input logic signed [15:0] a, b, c);
		@(posedge sys_clk);
		#2;
		{fsel[0], comb, p4p, p3p, p3a, p2a, p3o, p3s, p2o, p2s, fth, cth} = sw;
		p2 = a;
		p3 = b;
		p4 = c;
	endtask : drive

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		wait_cyc(12);
		rst_n = 1'b1;
		chk_ld(9'h000);
		chk_code(8'h00);
		// Two events in the hour: first clears, second holds
		for (int e = 0; e < 2; e++) begin
			cth = 1'b1;
			settle(7'h01);
			cth = 1'b0;
			wait_cyc(12);
			chk_act(e == 0 ? 7'h00 : 7'h01);
		end
		chk_latch(1'b1);
		mrst = 1'b1;
		settle(7'h00);
		chk_latch(1'b0);
		mrst = 1'b0;
		cth_lim = 8'h00;
		// Start blanking of three seconds
		blank = 8'h03;
		dem = 1'b1;
		wait_cyc(2);
		cth = 1'b1;
		wait_cyc(6);
		chk_act(7'h00);
		cth = 1'b0;
		wait_cyc(30);
		cth = 1'b1;
		settle(7'h01);
		chk_ld(9'h001);
		cth = 1'b0;
		blank = 8'h00;
		settle(7'h00);
		for (int i = 0; i < 17; i++) begin
			drive(rows[i].sw, rows[i].p2, rows[i].p3, rows[i].p4);
			settle(rows[i].act);
			chk_ld(rows[i].ld);
			chk_code(rows[i].num);
			chk_act(rows[i].act);
			drive(12'h000, 16'sd200, 16'sd0, 16'sd0);
			settle(7'h00);
		end
		// Hysteresis bands, inside the band the alarm holds
		drive(12'h800, 16'sd40, 16'sd0, 16'sd0);
		settle(7'h04);
		drive(12'h800, 16'sd60, 16'sd0, 16'sd0);
		wait_cyc(12);
		chk_act(7'h04);
		drive(12'h800, 16'sd90, 16'sd0, 16'sd0);
		settle(7'h00);
		drive(12'h100, 16'sd200, 16'sd250, 16'sd0);
		settle(7'h40);
		drive(12'h100, 16'sd200, 16'sd180, 16'sd0);
		wait_cyc(12);
		chk_act(7'h40);
		drive(12'h100, 16'sd200, 16'sd140, 16'sd0);
		settle(7'h00);
		// Armed counting with a limit of one latches the first event
		afz_lim = 8'h01;
		uon = 1'b1;
		heat = 1'b1;
		wait_cyc(1);
		heat = 1'b0;
		wait_cyc(6);
		drive(12'h800, 16'sd40, 16'sd0, 16'sd0);
		settle(7'h04);
		drive(12'h800, 16'sd200, 16'sd0, 16'sd0);
		wait_cyc(12);
		chk_act(7'h04);
		mrst = 1'b1;
		settle(7'h00);
		mrst = 1'b0;
		// Fan alarm at its limit waits for manual reset
		fth_lim = 8'h01;
		drive(12'h002, 16'sd200, 16'sd0, 16'sd0);
		settle(7'h02);
		drive(12'h000, 16'sd200, 16'sd0, 16'sd0);
		wait_cyc(12);
		chk_act(7'h02);
		chk_latch(1'b1);
		mrst = 1'b1;
		settle(7'h00);
		mrst = 1'b0;
		// Second event after the hour window has closed must not latch
		fth_lim = 8'h02;
		for (int e = 0; e < 2; e++) begin
			drive(12'h002, 16'sd200, 16'sd0, 16'sd0);
			settle(7'h02);
			drive(12'h000, 16'sd200, 16'sd0, 16'sd0);
			wait_cyc(e == 0 ? 14500 : 12);
		end
		chk_act(7'h00);
		chk_latch(1'b0);
		// Pressure switch never clears by itself
		hpd = 1'b1;
		settle(7'h20);
		chk_ld(9'h001);
		chk_code(8'h09);
		mrst = 1'b1;
		wait_cyc(12);
		chk_act(7'h20);
		mrst = 1'b0;
		hpd = 1'b0;
		wait_cyc(12);
		chk_act(7'h20);
		chk_latch(1'b1);
		// Reset in mid-run drops the held alarm
		rst_n = 1'b0;
		wait_cyc(2);
		chk_ld(9'h000);
		chk_act(7'h00);
		chk_latch(1'b0);
		rst_n = 1'b1;
		wait_cyc(10);
		chk_code(8'h00);
		tally_and_finish();
	end
endmodule : cpal_top_tb_top
